// ===== hdl/csc_pkg.sv
package csc_pkg;
    // Page-relative byte offsets
    localparam logic [7:0] OFF_REVISION = 8'h00;
    localparam logic [7:0] OFF_PAGE = 8'h01;
    localparam logic [7:0] OFF_PART_LOW = 8'h02;
    localparam logic [7:0] OFF_PART_HIGH = 8'h03;
    localparam logic [7:0] OFF_GRADE = 8'h04;
    // Full 16-bit addresses (page in upper byte)
    localparam logic [15:0] ADDR_REVISION = 16'h0000;
    localparam logic [15:0] ADDR_PART_LOW = 16'h0002;
    localparam logic [15:0] ADDR_PART_HIGH = 16'h0003;
    localparam logic [15:0] ADDR_GRADE = 16'h0004;
    localparam logic [15:0] ADDR_IN_EN = 16'h0949;
    localparam logic [15:0] ADDR_ROUTE = 16'h094A;
    localparam logic [15:0] ADDR_DIV_CLK = 16'h0A03;
    localparam logic [15:0] ADDR_PI_BYP = 16'h0A04;
    localparam logic [15:0] ADDR_DIV_PWR = 16'h0A05;
    localparam logic [15:0] ADDR_LOS_GATE = 16'h0B46;
    localparam logic [15:0] ADDR_CAL = 16'h0B49;
    localparam logic [15:0] ADDR_DIV_GATE = 16'h0B4A;
    // Field positions
    localparam int ROUTE_LSB = 4;
    localparam int FB_GATE_BIT = 5;
    localparam int FB_CAL_GATE_BIT = 6;
    localparam int CAL_INH_LSB = 0;
    localparam int CAL_OVR_LSB = 2;
    // Reset values
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [3:0] RST_IN_EN = 4'h0;
    localparam logic [2:0] RST_ROUTE = 3'h0;
    localparam logic [4:0] RST_DIV = 5'h00;
    localparam logic [3:0] RST_LOS_GATE = 4'h0;
    localparam logic [3:0] RST_CAL = 4'h0;
    localparam logic [6:0] RST_DIV_GATE = 7'h00;
    localparam logic [1:0] RST_SEL = 2'h0;

    typedef struct packed {
        logic [3:0] inputEnable;
        logic [2:0] routeToDetector;
        logic [2:0] detectorClockEnable;
        logic [4:0] dividerClock;
        logic [4:0] interpolatorBypass;
        logic [4:0] dividerPowerUp;
        logic [4:0] outputDividerClockGate;
        logic feedbackDividerClockGate;
        logic feedbackDividerCalGate;
        logic [3:0] signalLossClockGate;
        logic [1:0] calibrationInhibit;
        logic [1:0] calibrationOverride;
    } csc_ctrl_t;
endpackage

// ===== hdl/csc_config_regs.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Input enable bits switch each input
// - Routing bits gate clock inputs to detector
// - Input select picks the routed detector clock
// - Bypass bit skips divider phase interpolator
// - Zero in power field powers divider down
// - Bit 5 gates the feedback divider clock
// - Loss-detector clock gate stops detector when set
// - Page register at 0x01 on every page
// - Page register is eight bits wide
// - Two read-only bytes hold part number
// - Low nibble of address zero is revision
// - Read-only byte reports speed grade index
module csc_config_regs #(
    parameter logic [3:0] REVISION = 4'h0,    // Arbitrary value
    parameter logic [15:0] PART_NUMBER = 16'h1234, // Arbitrary value
    parameter logic [7:0] GRADE_CODE = 8'h00  // Arbitrary value
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regOffset,
    input wire logic [7:0] regWriteData,
    input wire logic [1:0] inputSelect,
    output logic [7:0] regReadData,
    output logic [7:0] currentPage,
    output csc_pkg::csc_ctrl_t ctrl
);
    logic [15:0] fullAddr;
    logic [3:0] inputEnable;
    logic [2:0] routeToDetector;
    logic [4:0] dividerClock;
    logic [4:0] interpolatorBypass;
    logic [4:0] dividerPowerUp;
    logic [3:0] signalLossClockGate;
    logic [3:0] calibration;
    logic [6:0] dividerGates;
    logic [1:0] selectedInput;
    logic [7:0] next_readData;

    // Page byte above host offset forms the register address
    assign fullAddr = {currentPage, regOffset};

    function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
        hit = (a == target);
    endfunction

    // Page register answers at offset 0x01 whatever the page
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            currentPage <= csc_pkg::RST_PAGE;
        else if (regWrite && regOffset == csc_pkg::OFF_PAGE)
            currentPage <= regWriteData;
    end

    // Identification addresses have no write path at all
    logic fieldWriteOk;
    assign fieldWriteOk = regWrite && regOffset != csc_pkg::OFF_PAGE;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            inputEnable <= csc_pkg::RST_IN_EN;
        else if (fieldWriteOk && hit(fullAddr, csc_pkg::ADDR_IN_EN))
            inputEnable <= regWriteData[3:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            routeToDetector <= csc_pkg::RST_ROUTE;
        else if (fieldWriteOk && hit(fullAddr, csc_pkg::ADDR_ROUTE))
            routeToDetector <= regWriteData[csc_pkg::ROUTE_LSB +: 3];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dividerClock <= csc_pkg::RST_DIV;
        else if (fieldWriteOk && hit(fullAddr, csc_pkg::ADDR_DIV_CLK))
            dividerClock <= regWriteData[4:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            interpolatorBypass <= csc_pkg::RST_DIV;
        else if (fieldWriteOk && hit(fullAddr, csc_pkg::ADDR_PI_BYP))
            interpolatorBypass <= regWriteData[4:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dividerPowerUp <= csc_pkg::RST_DIV;
        else if (fieldWriteOk && hit(fullAddr, csc_pkg::ADDR_DIV_PWR))
            dividerPowerUp <= regWriteData[4:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            signalLossClockGate <= csc_pkg::RST_LOS_GATE;
        else if (fieldWriteOk && hit(fullAddr, csc_pkg::ADDR_LOS_GATE))
            signalLossClockGate <= regWriteData[3:0];
    end

    // Stored as written; keeping these low is left to software
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            calibration <= csc_pkg::RST_CAL;
        else if (fieldWriteOk && hit(fullAddr, csc_pkg::ADDR_CAL))
            calibration <= regWriteData[3:0];
    end

    // A set gate bit stops a clock, so reset leaves every clock running
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dividerGates <= csc_pkg::RST_DIV_GATE;
        else if (fieldWriteOk && hit(fullAddr, csc_pkg::ADDR_DIV_GATE))
            dividerGates <= regWriteData[6:0];
    end

    // Select is an external strap level; synchronise before use
    // Only the second flop is read: the first may still be settling
    logic [1:0] selMeta;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            selMeta <= csc_pkg::RST_SEL;
        else
            selMeta <= inputSelect;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            selectedInput <= csc_pkg::RST_SEL;
        else
            selectedInput <= selMeta;
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        next_readData = 8'h00;
        if (regOffset == csc_pkg::OFF_PAGE)
        begin
            next_readData = currentPage;
        end
        else
        begin
            // Offset 0x01 never gets here, whatever the page
            unique case (fullAddr)
                csc_pkg::ADDR_REVISION:
                begin
                    next_readData = {4'h0, REVISION};
                end
                csc_pkg::ADDR_PART_LOW:
                begin
                    next_readData = PART_NUMBER[7:0];
                end
                csc_pkg::ADDR_PART_HIGH:
                begin
                    next_readData = PART_NUMBER[15:8];
                end
                csc_pkg::ADDR_GRADE:
                begin
                    next_readData = GRADE_CODE;
                end
                csc_pkg::ADDR_IN_EN:
                begin
                    next_readData = {4'h0, inputEnable};
                end
                csc_pkg::ADDR_ROUTE:
                begin
                    next_readData = {1'b0, routeToDetector, 4'h0};
                end
                csc_pkg::ADDR_DIV_CLK:
                begin
                    next_readData = {3'h0, dividerClock};
                end
                csc_pkg::ADDR_PI_BYP:
                begin
                    next_readData = {3'h0, interpolatorBypass};
                end
                csc_pkg::ADDR_DIV_PWR:
                begin
                    next_readData = {3'h0, dividerPowerUp};
                end
                csc_pkg::ADDR_LOS_GATE:
                begin
                    next_readData = {4'h0, signalLossClockGate};
                end
                csc_pkg::ADDR_CAL:
                begin
                    next_readData = {4'h0, calibration};
                end
                csc_pkg::ADDR_DIV_GATE:
                begin
                    next_readData = {1'b0, dividerGates};
                end
                default:
                begin
                    next_readData = 8'h00;
                end
            endcase
        end
    end

    // Read data holds between reads so the host may sample late
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            regReadData <= 8'h00;
        else if (regRead)
            regReadData <= next_readData;
    end

    // Control outputs registered from the fields, one process per ctrl member, one per bit of detectorClockEnable
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl.inputEnable <= csc_pkg::RST_IN_EN;
        else
            ctrl.inputEnable <= inputEnable;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl.routeToDetector <= csc_pkg::RST_ROUTE;
        else
            ctrl.routeToDetector <= routeToDetector;
    end

    // Only a routed, enabled clock input may reach the detector
    for (genvar i = 0; i < 3; i++)
    begin : gDetector
        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
                ctrl.detectorClockEnable[i] <= 1'b0;
            else
                ctrl.detectorClockEnable[i] <= routeToDetector[i] && inputEnable[i]
                    && selectedInput == 2'(i);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl.dividerClock <= csc_pkg::RST_DIV;
        else
            ctrl.dividerClock <= dividerClock;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl.interpolatorBypass <= csc_pkg::RST_DIV;
        else
            ctrl.interpolatorBypass <= interpolatorBypass;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl.dividerPowerUp <= csc_pkg::RST_DIV;
        else
            ctrl.dividerPowerUp <= dividerPowerUp;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl.outputDividerClockGate <= csc_pkg::RST_DIV_GATE[4:0];
        else
            ctrl.outputDividerClockGate <= dividerGates[4:0];
    end

    // Feedback gates share one byte with the output divider gates
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl.feedbackDividerClockGate <= csc_pkg::RST_DIV_GATE[csc_pkg::FB_GATE_BIT];
        else
            ctrl.feedbackDividerClockGate <= dividerGates[csc_pkg::FB_GATE_BIT];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl.feedbackDividerCalGate <= csc_pkg::RST_DIV_GATE[csc_pkg::FB_CAL_GATE_BIT];
        else
            ctrl.feedbackDividerCalGate <= dividerGates[csc_pkg::FB_CAL_GATE_BIT];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl.signalLossClockGate <= csc_pkg::RST_LOS_GATE;
        else
            ctrl.signalLossClockGate <= signalLossClockGate;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl.calibrationInhibit <= csc_pkg::RST_CAL[csc_pkg::CAL_INH_LSB +: 2];
        else
            ctrl.calibrationInhibit <= calibration[csc_pkg::CAL_INH_LSB +: 2];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl.calibrationOverride <= csc_pkg::RST_CAL[csc_pkg::CAL_OVR_LSB +: 2];
        else
            ctrl.calibrationOverride <= calibration[csc_pkg::CAL_OVR_LSB +: 2];
    end
endmodule // csc_config_regs

`default_nettype wire

// ===== sim/csc_config_regs_props.sv
`timescale 1ns/100ps
`default_nettype none
module csc_regs_props #(
    parameter logic [3:0] REVISION = 4'h0,
    parameter logic [15:0] PART_NUMBER = 16'h1234,
    parameter logic [7:0] GRADE_CODE = 8'h00
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regOffset,
    input wire logic [7:0] regWriteData,
    input wire logic [1:0] inputSelect,
    input wire logic [7:0] regReadData,
    input wire logic [7:0] currentPage,
    input wire csc_pkg::csc_ctrl_t ctrl
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic rd0 = regRead && currentPage == 8'h00;
    wire logic [15:0] addr = {currentPage, regOffset};
    property p_page;
        regWrite && regOffset == 8'h01 |=> currentPage == $past(regWriteData);
    endproperty
    a_page: assert property (p_page) else $error("page write lost");
    property p_page_rd;
        regRead && !regWrite && regOffset == 8'h01 |=> regReadData == $past(currentPage);
    endproperty
    a_page_rd: assert property (p_page_rd) else $error("page readback wrong");
    property p_rev;
        rd0 && regOffset == 8'h00 |=> regReadData[3:0] == REVISION;
    endproperty
    a_rev: assert property (p_rev) else $error("revision wrong");
    property p_part;
        rd0 && regOffset == 8'h02 |=> regReadData == PART_NUMBER[7:0];
    endproperty
    a_part: assert property (p_part) else $error("part number low wrong");
    property p_grade;
        rd0 && regOffset == 8'h04 |=> regReadData == GRADE_CODE;
    endproperty
    a_grade: assert property (p_grade) else $error("grade wrong");
    property p_in_en;
        regWrite && addr == csc_pkg::ADDR_IN_EN
            |=> ##1 ctrl.inputEnable == $past(regWriteData[3:0], 2);
    endproperty
    a_in_en: assert property (p_in_en) else $error("input enable wrong");
    property p_route;
        regWrite && addr == csc_pkg::ADDR_ROUTE
            |=> ##1 ctrl.routeToDetector == $past(regWriteData[6:4], 2);
    endproperty
    a_route: assert property (p_route) else $error("route field wrong");
    property p_sel;
        $onehot0(ctrl.detectorClockEnable)
            && (ctrl.detectorClockEnable & ~ctrl.routeToDetector) == 3'h0;
    endproperty
    a_sel: assert property (p_sel) else $error("detector clock not single");
    property p_gate;
        regWrite && addr == csc_pkg::ADDR_DIV_GATE |=> ##1 {ctrl.feedbackDividerCalGate,
            ctrl.feedbackDividerClockGate} == $past(regWriteData[6:5], 2);
    endproperty
    a_gate: assert property (p_gate) else $error("feedback gate wrong");
endmodule // csc_regs_props
bind csc_config_regs csc_regs_props #(.REVISION(REVISION), .PART_NUMBER(PART_NUMBER),
    .GRADE_CODE(GRADE_CODE)) uProps (.clk(clk), .rst(rst), .regWrite(regWrite),
    .regRead(regRead), .regOffset(regOffset), .regWriteData(regWriteData),
    .inputSelect(inputSelect), .regReadData(regReadData), .currentPage(currentPage),
    .ctrl(ctrl));
`default_nettype wire

// ===== sim/test_clock_synth_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_clock_synth_config_regs;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regOffset = 8'h00;
    logic [7:0] regWriteData = 8'h00;
    logic [1:0] inputSelect = 2'h0;
    logic [7:0] regReadData;
    logic [7:0] currentPage;
    csc_pkg::csc_ctrl_t ctrl;
    logic [7:0] expQ[$];
    logic [7:0] d;
    int errTotal = 0;
    int checked = 0;
    int cycles = 0;
    logic [15:0] addrs[8] = '{16'h0949, 16'h094A, 16'h0A03, 16'h0A04, 16'h0A05,
        16'h0B46, 16'h0B49, 16'h0B4A};
    logic [7:0] masks[8] = '{8'h0F, 8'h70, 8'h1F, 8'h1F, 8'h1F, 8'h0F, 8'h0F, 8'h7F};
    csc_config_regs DUT (.clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
        .regOffset(regOffset), .regWriteData(regWriteData), .inputSelect(inputSelect),
        .regReadData(regReadData), .currentPage(currentPage), .ctrl(ctrl));
    initial forever #10 clk = ~clk;
    task automatic print_verdict();
        if (errTotal == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            errTotal++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] o, input logic [7:0] v);
        @(negedge clk);
        regWrite = 1'b1;
        regOffset = o;
        regWriteData = v;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] o, input logic [7:0] e);
        @(negedge clk);
        regRead = 1'b1;
        regOffset = o;
        expQ.push_back(e);
        @(negedge clk);
        regRead = 1'b0;
    endtask
    // Read data lands one edge after the strobe, so compare just past that edge
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errTotal++;
            print_verdict();
        end
        if (regRead)
        begin
            #1;
            chk(regReadData, expQ.pop_front());
        end
    end
    initial
    begin
        void'($urandom(32'h5C68224A));
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        rd(8'h01, 8'h00);
        rd(8'h00, 8'h00);
        rd(8'h02, 8'h34);
        rd(8'h03, 8'h12);
        rd(8'h04, 8'h00);
        wr(8'h03, 8'hA5);
        rd(8'h03, 8'h12);
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'hFF);
        for (int i = 0; i < 8; i++)
        begin
            d = 8'($urandom());
            wr(8'h01, addrs[i][15:8]);
            wr(addrs[i][7:0], d);
            rd(addrs[i][7:0], d & masks[i]);
        end
        chk({1'b0, ctrl.feedbackDividerCalGate, ctrl.feedbackDividerClockGate,
            ctrl.outputDividerClockGate}, d & 8'h7F);
        wr(8'h01, 8'h0A);
        wr(8'h03, 8'h1F);
        wr(8'h04, 8'h15);
        wr(8'h05, 8'h0B);
        wr(8'h01, 8'h0B);
        wr(8'h46, 8'h05);
        wr(8'h49, 8'h00);
        wr(8'h4A, 8'h00);
        @(negedge clk);
        chk({3'h0, ctrl.dividerClock}, 8'h1F);
        chk({3'h0, ctrl.interpolatorBypass}, 8'h15);
        chk({3'h0, ctrl.dividerPowerUp}, 8'h0B);
        chk({4'h0, ctrl.signalLossClockGate}, 8'h05);
        chk({4'h0, ctrl.calibrationOverride, ctrl.calibrationInhibit}, 8'h00);
        chk({1'b0, ctrl.feedbackDividerCalGate, ctrl.feedbackDividerClockGate,
            ctrl.outputDividerClockGate}, 8'h00);
        rd(8'h06, 8'h00);
        wr(8'h01, 8'h09);
        wr(8'h49, 8'h07);
        wr(8'h4A, 8'h70);
        for (int s = 0; s < 4; s++)
        begin
            inputSelect = 2'(s);
            repeat (5) @(negedge clk);
            chk({5'h00, ctrl.detectorClockEnable}, s < 3 ? 8'(1 << s) : 8'h00);
        end
        chk({4'h0, ctrl.inputEnable}, 8'h07);
        @(negedge clk) rst = 1'b1;
        @(negedge clk) rst = 1'b0;
        chk(currentPage, 8'h00);
        chk({4'h0, ctrl.inputEnable}, 8'h00);
        rd(8'h01, 8'h00);
        print_verdict();
    end
endmodule // test_clock_synth_config_regs
`default_nettype wire
